// >>> core/dma_cc_activity_status.sv
// What this block does
// - Busy bit 4 is the OR of every activity flag in status and of outstanding transfers.
// - Busy stays high from request acceptance until processing finishes.
// - Bit 3 high while write-status request active or responses queued.
// - Bit 2 high while request processing and submission logic works.
// - Bit 1 high when any enabled QDMA event is pending.
// - Bit 0 high for enabled latched, manually set or chained DMA event.
// - Status bits 7 to 5 always read zero.
// - Per-channel registers are 32 bits, bit n serving channel n.
// - Channel registers reachable globally and aliased in shadow regions.
// - Shadow accesses touch only channels granted by region access mask.
// - Queue flag high while its event queue holds a request; feeds busy.
`timescale 1ns/10ps

module dma_cc_activity_status
    import cc_status_pkg::*;
#(
    parameter int NUM_CHANNELS = DATA_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire activity_t activity,
    input wire logic [NUM_CHANNELS-1:0] dma_event_in,
    input wire logic [NUM_CHANNELS-1:0] chain_event_in,
    input wire logic [NUM_CHANNELS-1:0] service_done,
    input wire logic [DATA_W-1:0] qdma_event_flags,
    input wire reg_req_t reg_req,
    output logic [DATA_W-1:0] rd_data_q,
    output logic rd_valid_q,
    output logic [DATA_W-1:0] controller_status_q
);

    // Channel flags share one data word, so wider configurations are refused
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > DATA_W) begin : gen_bad_channels
        $error("NUM_CHANNELS must lie between 1 and DATA_W");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Channels an access may touch: all globally, granted ones in a shadow
    function automatic logic [DATA_W-1:0] access_mask(
        input logic shadow,
        input logic [DATA_W-1:0] grant
    );
        access_mask = shadow ? grant : {DATA_W{1'b1}};
    endfunction : access_mask

    // Offset of the access mask register of one region
    function automatic logic [OFFS_W-1:0] region_offset(input int idx);
        region_offset = OFFS_REGION_BASE
            + OFFS_REGION_STEP * OFFS_W'(idx);
    endfunction : region_offset

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic [DATA_W-1:0] region_access_mask_q [NUM_REGIONS];
    logic [DATA_W-1:0] event_enable_mask_q;
    logic [NUM_CHANNELS-1:0] dma_event_latch;
    logic [NUM_CHANNELS-1:0] manual_event_set;
    logic [NUM_CHANNELS-1:0] chained_event_flags;
    logic [DATA_W-1:0] grant;
    logic [DATA_W-1:0] wmask;
    logic wr;
    logic hit_clear;
    logic hit_set;
    logic hit_enable;
    logic [NUM_REGIONS-1:0] hit_region;

    // Shadow grant comes from the selected region's mask
    assign grant = region_access_mask_q[reg_req.region];
    assign wmask = reg_req.wdata & access_mask(reg_req.shadow, grant);
    assign wr = reg_req.valid & reg_req.write;
    assign hit_clear = wr & (reg_req.offset == OFFS_EVT_CLEAR);
    assign hit_set = wr & (reg_req.offset == OFFS_MANUAL_SET);
    assign hit_enable = wr & (reg_req.offset == OFFS_ENABLE);

    // Region masks are programmed only through the global range
    genvar g;
    generate
        for (g = 0; g < NUM_REGIONS; g++) begin : gen_region_hit
            assign hit_region[g] = wr & ~reg_req.shadow
                & (reg_req.offset == region_offset(g));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Per-channel flag registers, bit n is channel n

    logic [NUM_CHANNELS-1:0] clear_wr;
    logic [NUM_CHANNELS-1:0] set_wr;

    assign clear_wr = hit_clear ? wmask[NUM_CHANNELS-1:0] : '0;
    assign set_wr = hit_set ? wmask[NUM_CHANNELS-1:0] : '0;

    // Hardware events latch even when disabled
    channel_flag_reg #(.WIDTH(NUM_CHANNELS)) u_event_latch (
        .sys_clk(sys_clk),
        .rst(rst),
        .set_bits(dma_event_in),
        .clear_bits(clear_wr | service_done),
        .flags_q(dma_event_latch)
    );

    // Manual sets ignore the clear register; only servicing clears them
    channel_flag_reg #(.WIDTH(NUM_CHANNELS)) u_manual_set (
        .sys_clk(sys_clk),
        .rst(rst),
        .set_bits(set_wr),
        .clear_bits(service_done),
        .flags_q(manual_event_set)
    );

    // Chained events from completing channels
    channel_flag_reg #(.WIDTH(NUM_CHANNELS)) u_chained (
        .sys_clk(sys_clk),
        .rst(rst),
        .set_bits(chain_event_in),
        .clear_bits(service_done),
        .flags_q(chained_event_flags)
    );

    // Enable mask, written whole bits only where the access may reach
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            event_enable_mask_q <= FLAGS_RESET;
        end else if (hit_enable) begin
            event_enable_mask_q <= (event_enable_mask_q
                & ~access_mask(reg_req.shadow, grant)) | wmask;
        end
    end

    // Region access masks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                region_access_mask_q[i] <= FLAGS_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_REGIONS; i++) begin
                if (hit_region[i]) begin
                    region_access_mask_q[i] <= reg_req.wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Activity status

    logic dma_event_pending;
    logic qdma_event_pending;
    logic request_logic_busy;
    logic write_status_pending;
    logic cc_busy_summary;
    logic [NUM_QUEUES-1:0] queue_nonempty;
    logic [DATA_W-1:0] status_d;

    // Manual and chained events count regardless of the enable mask
    assign dma_event_pending = |((dma_event_latch
        & event_enable_mask_q[NUM_CHANNELS-1:0])
        | manual_event_set | chained_event_flags);
    assign qdma_event_pending = |qdma_event_flags;
    assign request_logic_busy = activity.tr_logic_active;
    assign write_status_pending = activity.wstat_req_active
        | activity.wstat_fifo_pending;

    generate
        for (g = 0; g < NUM_QUEUES; g++) begin : gen_queue
            assign queue_nonempty[g] = activity.queue_count[g] != '0;
        end
    endgenerate

    // Outstanding transfers keep busy high until fully finished
    assign cc_busy_summary = dma_event_pending | qdma_event_pending
        | request_logic_busy | write_status_pending
        | (|queue_nonempty) | activity.xfer_outstanding;

    // Reserved bits, including 7 to 5, are left at zero
    always_comb begin
        status_d = STATUS_RESET;
        status_d[STAT_DMA_EVT] = dma_event_pending;
        status_d[STAT_QDMA_EVT] = qdma_event_pending;
        status_d[STAT_REQ_LOGIC] = request_logic_busy;
        status_d[STAT_WSTAT] = write_status_pending;
        status_d[STAT_BUSY] = cc_busy_summary;
        status_d[STAT_QUEUE_BASE +: NUM_QUEUES] = queue_nonempty;
    end

    // Status is never a write target, so bus writes cannot disturb it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            controller_status_q <= STATUS_RESET;
        end else begin
            controller_status_q <= status_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rd_region;

    // Region mask read back, global range only
    always_comb begin
        rd_region = '0;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            if (!reg_req.shadow && reg_req.offset == region_offset(i)) begin
                rd_region = region_access_mask_q[i];
            end
        end
    end

    // Unmapped and write-only offsets read as zero
    always_comb begin
        if (reg_req.offset == OFFS_STATUS) begin
            rd_mux = controller_status_q;
        end else if (reg_req.offset == OFFS_EVT_LATCH) begin
            rd_mux = DATA_W'(dma_event_latch);
        end else if (reg_req.offset == OFFS_MANUAL_SET) begin
            rd_mux = DATA_W'(manual_event_set);
        end else if (reg_req.offset == OFFS_CHAINED) begin
            rd_mux = DATA_W'(chained_event_flags);
        end else if (reg_req.offset == OFFS_ENABLE) begin
            rd_mux = event_enable_mask_q;
        end else begin
            rd_mux = rd_region;
        end
    end

    // Reads answer one cycle later, shadow data except status masked per channel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= STATUS_RESET;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_req.valid & ~reg_req.write;
            if (reg_req.valid && !reg_req.write) begin
                rd_data_q <= (reg_req.offset == OFFS_STATUS) ? rd_mux
                    : rd_mux & access_mask(reg_req.shadow, grant);
            end
        end
    end

endmodule : dma_cc_activity_status

// >>> core/cc_status_pkg.sv
package cc_status_pkg;

    // Data path and channel organisation
    localparam int DATA_W = 32;
    localparam int NUM_QUEUES = 2;
    localparam int QCNT_W = 5;
    localparam int NUM_REGIONS = 4;
    localparam int REGION_W = 2;
    localparam int OFFS_W = 12;

    // Status register field positions
    localparam int STAT_DMA_EVT = 0;
    localparam int STAT_QDMA_EVT = 1;
    localparam int STAT_REQ_LOGIC = 2;
    localparam int STAT_WSTAT = 3;
    localparam int STAT_BUSY = 4;
    localparam int STAT_QUEUE_BASE = 16;
    localparam logic [DATA_W-1:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] FLAGS_RESET = 32'h0000_0000;

    // Register offsets in every address range; region masks in the global range only
    localparam logic [OFFS_W-1:0] OFFS_STATUS = 12'h000;
    localparam logic [OFFS_W-1:0] OFFS_EVT_LATCH = 12'h100;
    localparam logic [OFFS_W-1:0] OFFS_EVT_CLEAR = 12'h108;
    localparam logic [OFFS_W-1:0] OFFS_MANUAL_SET = 12'h110;
    localparam logic [OFFS_W-1:0] OFFS_CHAINED = 12'h118;
    localparam logic [OFFS_W-1:0] OFFS_ENABLE = 12'h120;
    localparam logic [OFFS_W-1:0] OFFS_REGION_BASE = 12'h200;
    localparam logic [OFFS_W-1:0] OFFS_REGION_STEP = 12'h008;

    // Activity sources from the rest of the channel controller
    typedef struct packed {
        logic wstat_req_active;
        logic wstat_fifo_pending;
        logic tr_logic_active;
        logic xfer_outstanding;
        logic [NUM_QUEUES-1:0][QCNT_W-1:0] queue_count;
    } activity_t;

    // One register access, global or through a shadow region
    typedef struct packed {
        logic valid;
        logic write;
        logic shadow;
        logic [REGION_W-1:0] region;
        logic [OFFS_W-1:0] offset;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage : cc_status_pkg

// >>> core/channel_flag_reg.sv
`timescale 1ns/10ps

// Sticky per-channel flags; a set in the same cycle as a clear wins
module channel_flag_reg
    import cc_status_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set_bits,
    input wire logic [WIDTH-1:0] clear_bits,
    output logic [WIDTH-1:0] flags_q
);

    logic [WIDTH-1:0] flags_d;

    // Set has priority so an event racing its own clear is not lost
    assign flags_d = (flags_q & ~clear_bits) | set_bits;

    // Flag storage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_q <= FLAGS_RESET[WIDTH-1:0];
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule : channel_flag_reg

// >>> tb/dma_cc_activity_status_properties.sv
`timescale 1ns/10ps

// Port-level checker for the activity status block
module cc_status_checker
    import cc_status_pkg::*;
#(
    parameter int NUM_CHANNELS = DATA_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire activity_t activity,
    input wire logic [NUM_CHANNELS-1:0] dma_event_in,
    input wire logic [NUM_CHANNELS-1:0] chain_event_in,
    input wire logic [NUM_CHANNELS-1:0] service_done,
    input wire logic [DATA_W-1:0] qdma_event_flags,
    input wire reg_req_t reg_req,
    input wire logic [DATA_W-1:0] rd_data_q,
    input wire logic rd_valid_q,
    input wire logic [DATA_W-1:0] controller_status_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [1:0] age_q;
    logic live;
    logic rd_req;
    logic set_req;
    ////////////////////////////////////////////////////////////////////////
    // Status lags reset by an edge, so skip the first edges after release
    assign live = age_q == 2'h2;
    assign rd_req = reg_req.valid && !reg_req.write;
    assign set_req = reg_req.valid && reg_req.write && !reg_req.shadow
        && reg_req.offset == OFFS_MANUAL_SET && |reg_req.wdata;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            age_q <= 2'h0;
        end else if (!live) begin
            age_q <= age_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    AST_RSV: assert property (controller_status_q[7:5] == 3'h0)
        else $error("reserved status bits not zero");
    AST_WSTAT: assert property (live |->
        controller_status_q[STAT_WSTAT] == ($past(activity.wstat_req_active)
        || $past(activity.wstat_fifo_pending)))
        else $error("write status flag wrong");
    AST_TRL: assert property (live |->
        controller_status_q[STAT_REQ_LOGIC] == $past(activity.tr_logic_active))
        else $error("request logic flag wrong");
    AST_QEVT: assert property (live |->
        controller_status_q[STAT_QDMA_EVT] == ($past(qdma_event_flags) != '0))
        else $error("qdma flag wrong");
    AST_QUEUE: assert property (live |-> controller_status_q[17:16] ==
        {$past(activity.queue_count[1]) != 5'h00,
        $past(activity.queue_count[0]) != 5'h00})
        else $error("queue flag wrong");
    AST_BUSY: assert property (live |->
        controller_status_q[STAT_BUSY] == (|controller_status_q[3:0]
        || |controller_status_q[17:16] || $past(activity.xfer_outstanding)))
        else $error("busy not the OR");
    AST_HOLD: assert property (live && $fell(activity.xfer_outstanding)
        |-> controller_status_q[STAT_BUSY]) else $error("busy dropped early");
    AST_CHAIN: assert property (live && |chain_event_in
        |-> ##2 controller_status_q[STAT_DMA_EVT])
        else $error("chain not pending");
    AST_MANUAL: assert property (live && set_req
        |-> ##2 controller_status_q[STAT_DMA_EVT])
        else $error("manual not pending");
    AST_RDV: assert property (rd_req |=> rd_valid_q)
        else $error("read not answered");
    AST_RDSTAT: assert property (rd_req && reg_req.offset == OFFS_STATUS
        |=> rd_data_q == $past(controller_status_q))
        else $error("status read bad");
endmodule : cc_status_checker

bind dma_cc_activity_status cc_status_checker #(.NUM_CHANNELS(NUM_CHANNELS))
    cc_status_checker_i (.sys_clk(sys_clk), .rst(rst), .activity(activity),
    .dma_event_in(dma_event_in), .chain_event_in(chain_event_in),
    .service_done(service_done), .qdma_event_flags(qdma_event_flags),
    .reg_req(reg_req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .controller_status_q(controller_status_q));

// >>> tb/xfer_ctrl_model.sv
`timescale 1ns/10ps

// Transfer controller stand-in: reports a submitted request at once,
// then stays busy for lat cycles; lat 0 models a prompt controller
module xfer_ctrl_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic submit,
    input wire logic [4:0] chan,
    input wire logic [3:0] lat,
    output logic [31:0] done_q,
    output logic busy
);
    logic [3:0] cnt_q;
    assign busy = cnt_q != 4'h0;
    // A new submission restarts the hold count
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            done_q <= 32'h0000_0000;
        end else begin
            done_q <= submit ? (32'h0000_0001 << chan) : 32'h0000_0000;
            cnt_q <= submit ? lat : cnt_q - {3'h0, busy};
        end
    end
endmodule : xfer_ctrl_model

// >>> tb/test_dma_cc_activity_status.sv
`timescale 1ns/10ps

module test_dma_cc_activity_status;
    import cc_status_pkg::*;
    logic sys_clk, rst, rvalid, submit, xbusy;
    logic [4:0] chan;
    logic [3:0] lat;
    logic [31:0] dev_in, chn_in, qflags, rdata, stat, done;
    activity_t act, act_w;
    reg_req_t req;
    int failures = 0;
    int compares = 0;
    // Transfer controller owns the outstanding flag
    assign act_w = '{act.wstat_req_active, act.wstat_fifo_pending,
        act.tr_logic_active, xbusy, act.queue_count};
    dma_cc_activity_status dma_cc_activity_status_i (.sys_clk(sys_clk),
        .rst(rst), .activity(act_w), .dma_event_in(dev_in),
        .chain_event_in(chn_in), .service_done(done),
        .qdma_event_flags(qflags), .reg_req(req), .rd_data_q(rdata),
        .rd_valid_q(rvalid), .controller_status_q(stat));
    xfer_ctrl_model xfer_ctrl_model_i (.sys_clk(sys_clk), .rst(rst),
        .submit(submit), .chan(chan), .lat(lat), .done_q(done), .busy(xbusy));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    // One register access after an idle cycle, so a release and the next
    // request never share a time step; valid spans one rising edge
    task automatic acc(input logic w, sh, input logic [1:0] rg,
        input logic [11:0] of, input logic [31:0] d);
        tick(1);
        req <= '{1'b1, w, sh, rg, of, d};
        tick(1);
        req.valid <= 1'b0;
    endtask : acc
    task automatic rd(input logic sh, input logic [1:0] rg,
        input logic [11:0] of, input logic [31:0] exp);
        acc(1'b0, sh, rg, of, 32'h0000_0000);
        chk("rd_valid", 32'h0000_0001, {31'h0, rvalid});
        chk("rd_data", exp, rdata);
    endtask : rd
    // Submit for a channel, then wait two cycles for its flags to clear; the controller may still be busy
    task automatic serve(input logic [4:0] c, input logic [3:0] l);
        chan <= c;
        lat <= l;
        submit <= 1'b1;
        tick(1);
        submit <= 1'b0;
        tick(2);
    endtask : serve
    ////////////////////////////////////////////////////////////////////////
    task automatic t_act();
        for (int i = 0; i < 3; i++) begin
            {act.wstat_req_active, act.wstat_fifo_pending,
                act.tr_logic_active} <= 3'(1 << i);
            tick(1);
            chk("status", i == 0 ? 32'h0000_0014 : 32'h0000_0018, stat);
        end
        {act.wstat_req_active, act.tr_logic_active} <= 2'h0;
        act.queue_count <= {5'h01, 5'h1f};
        qflags <= 32'h8000_0000;
        tick(1);
        chk("status", 32'h0003_0012, stat);
        rd(1'b0, 2'h0, OFFS_STATUS, 32'h0003_0012);
        act <= '0;
        qflags <= 32'h0000_0000;
        tick(1);
        chk("status", 32'h0000_0000, stat);
    endtask : t_act
    task automatic t_dma();
        dev_in <= 32'h0000_0008;
        tick(1);
        dev_in <= 32'h0000_0000;
        tick(1);
        chk("status", 32'h0000_0000, stat);
        rd(1'b0, 2'h0, OFFS_EVT_LATCH, 32'h0000_0008);
        acc(1'b1, 1'b0, 2'h0, OFFS_ENABLE, 32'h0000_0008);
        tick(1);
        chk("status", 32'h0000_0011, stat);
        serve(5'd3, 4'h4);
        chk("status", 32'h0000_0010, stat);
        tick(4);
        chk("status", 32'h0000_0000, stat);
    endtask : t_dma
    task automatic t_shadow();
        acc(1'b1, 1'b0, 2'h0, OFFS_REGION_BASE + OFFS_REGION_STEP,
            32'h0000_0020);
        acc(1'b1, 1'b1, 2'h1, OFFS_MANUAL_SET, 32'h0000_0030);
        rd(1'b0, 2'h0, OFFS_MANUAL_SET, 32'h0000_0020);
        rd(1'b1, 2'h0, OFFS_MANUAL_SET, 32'h0000_0000);
        rd(1'b1, 2'h1, OFFS_MANUAL_SET, 32'h0000_0020);
        chk("status", 32'h0000_0011, stat);
        serve(5'd5, 4'h0);
        chk("status", 32'h0000_0000, stat);
    endtask : t_shadow
    task automatic t_ro();
        acc(1'b1, 1'b0, 2'h0, OFFS_STATUS, 32'hffff_ffff);
        acc(1'b1, 1'b0, 2'h0, OFFS_EVT_LATCH, 32'hffff_ffff);
        chk("status", 32'h0000_0000, stat);
        rd(1'b0, 2'h0, OFFS_EVT_LATCH, 32'h0000_0000);
        rd(1'b0, 2'h0, 12'h7fc, 32'h0000_0000);
        chn_in <= 32'h8000_0000;
        tick(1);
        chn_in <= 32'h0000_0000;
        tick(1);
        chk("status", 32'h0000_0011, stat);
        serve(5'd31, 4'h0);
        chk("status", 32'h0000_0000, stat);
    endtask : t_ro
    // Clear register, shadow grant on clear and enable, global manual set
    task automatic t_clear();
        dev_in <= 32'h0000_0001;
        tick(1);
        dev_in <= 32'h0000_0000;
        acc(1'b1, 1'b1, 2'h1, OFFS_EVT_CLEAR, 32'h0000_0001);
        rd(1'b0, 2'h0, OFFS_EVT_LATCH, 32'h0000_0001);
        acc(1'b1, 1'b0, 2'h0, OFFS_EVT_CLEAR, 32'h0000_0001);
        rd(1'b0, 2'h0, OFFS_EVT_LATCH, 32'h0000_0000);
        acc(1'b1, 1'b1, 2'h1, OFFS_ENABLE, 32'hffff_ffff);
        rd(1'b0, 2'h0, OFFS_ENABLE, 32'h0000_0028);
        acc(1'b1, 1'b0, 2'h0, OFFS_MANUAL_SET, 32'h0000_0002);
        tick(1);
        chk("status", 32'h0000_0011, stat);
        serve(5'd1, 4'h0);
        chk("status", 32'h0000_0000, stat);
    endtask : t_clear
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Whole run is under a hundred cycles
    initial begin
        #20000;
        failures++;
        end_sim();
    end
    initial begin
        {act, req, dev_in, chn_in, qflags, submit, chan, lat} = '0;
        rst = 1'b1;
        tick(8);
        rst <= 1'b0;
        tick(2);
        chk("status", STATUS_RESET, stat);
        t_act();
        t_dma();
        t_shadow();
        t_ro();
        t_clear();
        end_sim();
    end
endmodule : test_dma_cc_activity_status
